// ==== rtl/tbm_ctrl.sv ====
// three-bank external memory controller with wishbone registers
//
// Added by the designer: register access over Wishbone.
`include "tbm_params.svh"
`default_nettype none
// Contract
// - transmit structures go to bank A
// - receive structures go to bank B
// - network interface data goes to bank C
// - up to four SRAM chips, 128K to 1M
// - at most two megabytes SRAM per bank
// - bank C also serves 16M or 32M SDRAM
// - banks A and B 16 bits, C 32 bits
// - SDRAM may be two x16 parts side by side
// - bank C shares address and data pins
// - pipelined or flow-through SRAM, no turnaround
// - priority grant, converted to pin signalling
// - even parity driven on every write except unchecked receive circular buffers
// - read parity checked, mismatch reported in status
// - mask registers select bits entering parity
// - receive circular buffers carry underrun, not parity
// - control bit enables parity on circular buffers
// - periodic refresh, backlog over limit flags error
// - CPU issues manual SDRAM commands
module tbm_ctrl
   import tbm_pkg::*;
#(
   parameter int NAG = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [13:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   input wire tbm_req_s agentReq [NAG],
   output logic [NAG-1:0] agentGnt,
   output var tbm_rsp_s bankRsp [3],
   output var tbm_sram_s memOut [3],
   input wire tbm_memin_s memIn [3],
   output var tbm_sdram_s sdOut
);
   if (NAG < 1 || NAG > 4) begin : gBadNag
      $error("agent count must lie between 1 and 4");
   end

   // byte-lane merge for register writes
   function automatic logic [31:0] mrg(input logic [31:0] o,
         input logic [31:0] d, input logic [3:0] s);
      mrg = o;
      for (int j = 0; j < 4; j++) begin
         if (s[j]) mrg[8*j +: 8] = d[8*j +: 8];
      end
   endfunction : mrg

   // even parity per 16-bit lane, address parity folded into lane 0
   function automatic logic [1:0] genPar(input logic [31:0] d,
         input logic ap, input logic [15:0] m);
      genPar = {^(d[31:16] & m), ap ^ (^(d[15:0] & m))};
   endfunction : genPar

   // low address bits pass the mask, high bits always count
   function automatic logic addrPar(input logic [19:0] w,
         input logic [15:0] m);
      addrPar = (^(w[15:0] & m)) ^ (^w[19:16]);
   endfunction : addrPar

   // first eligible agent counting up from the base
   function automatic logic [2:0] pickAg(input logic [3:0] el,
         input logic [1:0] base);
      logic [1:0] ix;
      pickAg = 3'h0;
      for (int k = 3; k >= 0; k--) begin
         ix = base + 2'(k);
         if (el[ix]) pickAg = {1'b1, ix};
      end
   endfunction : pickAg

   logic rstMeta_r, rstN;
   logic [15:0] pmFirst_r, pmLast_r, refPer_r, refLim_r, ctrl_r;
   logic [19:0] man_r;
   logic manGo_r, refErr_r, manTake, refDone, tick;
   logic [2:0] parErr_r, rangeErr_r, perr, rangeHit, pipeEmpty, gHit;
   logic [15:0] refCnt_r;
   logic [7:0] backlog_r, stClr;
   logic [31:0] rdData;
   logic wbReq, wbWr;
   logic [11:0] wbIx;
   logic [1:0] gIdx [3];
   tbm_req_s gReq [3];
   tbm_pipe_s gItem [3];
   logic [NAG-1:0] gntNxt;
   tbm_sd_e sdSt_r, stN;
   logic [3:0] sdCnt_r, cntN, cmdN;
   logic [1:0] baN;
   tbm_pipe_s sdItem_r, sdRet;
   logic [12:0] sdCol_r;
   logic sdIdle, sdGrant, sdPinUse, sdPinDoeN;
   logic [19:0] sdPinAddr;
   logic [31:0] sdPinDout;
   logic [1:0] sdPinPar;
   logic [12:0] sdRow;

   // reset release through two flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstN <= rstMeta_r;
      end
   end

   assign wbReq = wbCyc && wbStb && !wbAck;
   assign wbWr = wbReq && wbWe;
   assign wbIx = wbAdr[13:2];

   // configuration registers written by software
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         pmFirst_r <= `TBM_RST_PMASK;
         pmLast_r <= `TBM_RST_PMASK;
         refPer_r <= `TBM_RST_REF_PERIOD;
         refLim_r <= `TBM_RST_REF_LIMIT;
         ctrl_r <= `TBM_RST_CTRL;
      end else if (wbWr) begin
         if (wbIx == `TBM_IX_PMASK_FIRST) begin
            pmFirst_r <= 16'(mrg({16'h0, pmFirst_r}, wbDatIn, wbSel));
         end else if (wbIx == `TBM_IX_PMASK_LAST) begin
            pmLast_r <= 16'(mrg({16'h0, pmLast_r}, wbDatIn, wbSel));
         end else if (wbIx == `TBM_IX_REF_PERIOD) begin
            refPer_r <= 16'(mrg({16'h0, refPer_r}, wbDatIn, wbSel));
         end else if (wbIx == `TBM_IX_REF_LIMIT) begin
            refLim_r <= 16'(mrg({16'h0, refLim_r}, wbDatIn, wbSel));
         end else if (wbIx == `TBM_IX_CTRL) begin
            ctrl_r <= 16'(mrg({16'h0, ctrl_r}, wbDatIn, wbSel));
         end
      end
   end

   // manual sdram command, fields frozen while a command waits
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         man_r <= `TBM_RST_MAN;
         manGo_r <= 1'b0;
      end else begin
         if (wbWr && wbIx == `TBM_IX_MAN && !manGo_r) begin
            man_r <= 20'(mrg({12'h0, man_r}, wbDatIn, wbSel));
         end
         manGo_r <= (manGo_r && !manTake) || (wbWr && wbIx == `TBM_IX_MAN
            && wbSel[3] && wbDatIn[`TBM_MAN_GO]);
      end
   end

   // sticky error flags, write one to clear, a new event wins
   assign stClr = (wbWr && wbIx == `TBM_IX_STAT && wbSel[0]) ?
      wbDatIn[7:0] : 8'h00;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         parErr_r <= 3'h0;
         rangeErr_r <= 3'h0;
         refErr_r <= 1'b0;
      end else begin
         parErr_r <= (parErr_r & ~stClr[`TBM_ST_PAR +: 3])
            | perr;
         rangeErr_r <= (rangeErr_r & ~stClr[`TBM_ST_RANGE +: 3])
            | rangeHit;
         refErr_r <= (refErr_r && !stClr[`TBM_ST_REFERR])
            || ({8'h0, backlog_r} > refLim_r);
      end
   end

   // refresh period timer and backlog of owed refreshes
   assign tick = refPer_r != 16'h0 && refCnt_r == refPer_r - 16'h1;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         refCnt_r <= 16'h0;
         backlog_r <= 8'h0;
      end else begin
         refCnt_r <= (refPer_r == 16'h0 || tick) ? 16'h0
            : refCnt_r + 16'h1;
         if (tick && !refDone && backlog_r != 8'hff) begin
            backlog_r <= backlog_r + 8'h1;
         end else if (!tick && refDone) begin
            backlog_r <= backlog_r - 8'h1;
         end
      end
   end

   // register read selection
   always_comb begin
      rdData = 32'h0;
      if (wbIx == `TBM_IX_PMASK_FIRST) begin
         rdData[15:0] = pmFirst_r;
      end else if (wbIx == `TBM_IX_PMASK_LAST) begin
         rdData[15:0] = pmLast_r;
      end else if (wbIx == `TBM_IX_REF_PERIOD) begin
         rdData[15:0] = refPer_r;
      end else if (wbIx == `TBM_IX_REF_LIMIT) begin
         rdData[15:0] = refLim_r;
      end else if (wbIx == `TBM_IX_CTRL) begin
         rdData[15:0] = ctrl_r;
      end else if (wbIx == `TBM_IX_STAT) begin
         rdData[`TBM_ST_PAR +: 3] = parErr_r;
         rdData[`TBM_ST_RANGE +: 3] = rangeErr_r;
         rdData[`TBM_ST_REFERR] = refErr_r;
         rdData[`TBM_ST_MANBUSY] = manGo_r;
         rdData[`TBM_ST_BACKLOG +: 8] = backlog_r;
      end else if (wbIx == `TBM_IX_MAN) begin
         rdData[19:0] = man_r;
         rdData[`TBM_MAN_GO] = manGo_r;
      end
   end

   // wishbone answer one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         wbAck <= 1'b0;
         wbDatOut <= 32'h0;
      end else begin
         wbAck <= wbReq;
         wbDatOut <= (wbReq && !wbWe) ? rdData : 32'h0;
      end
   end

   assign sdIdle = sdSt_r == ST_IDLE;

   for (genvar b = 0; b < 3; b++) begin : gBank
      logic [3:0] el;
      logic [2:0] pk;
      logic [1:0] sz, chip;
      logic [19:0] wa;
      logic ok, issue, pipeSel, mism;
      logic [1:0] expPar;
      logic [31:0] rdD;
      tbm_req_s g;
      tbm_pipe_s it, s1_r, s2_r, s3_r, wrIt, rdIt, r;

      // requests of this bank's class only, bank C also waits on sdram
      always_comb begin
         el = 4'h0;
         for (int i = 0; i < NAG; i++) begin
            el[i] = agentReq[i].valid && !agentGnt[i]
               && agentReq[i].bank == tbm_bank_e'(2'(b));
            if (b == 2) begin
               el[i] = el[i] && sdIdle && !manGo_r && backlog_r == 8'h0
                  && (!agentReq[i].sdram || pipeEmpty[2]);
            end
         end
      end
      assign pk = pickAg(el, ctrl_r[`TBM_CTRL_PRIO +: 2]);
      assign g = agentReq[pk[1:0]];
      assign sz = ctrl_r[`TBM_CTRL_SZ + 2*b +: 2];
      assign wa = (b == 2) ? g.addr[21:2] : g.addr[20:1];
      assign chip = 2'(g.addr >> (`TBM_CHIP_LOG2_MIN + sz));
      assign ok = (g.addr >> (`TBM_CHIP_LOG2_MIN + 2 + sz)) == 0
         && (g.addr >> `TBM_BANK_LOG2_MAX) == 0;
      assign issue = pk[2] && !(b == 2 && g.sdram);
      assign gHit[b] = pk[2];
      assign gIdx[b] = pk[1:0];
      assign gReq[b] = g;
      assign gItem[b] = it;
      assign rangeHit[b] = issue && !ok;

      // access descriptor that follows the address down the pipe
      always_comb begin
         it = '0;
         it.valid = issue;
         it.write = g.write;
         it.chk = !g.rxCirc || ctrl_r[`TBM_CTRL_RXPAR];
         it.under = g.underrun;
         it.ok = ok;
         it.agent = pk[1:0];
         it.apar = addrPar(wa, pmLast_r);
         it.data = (b == 2) ? g.data : {16'h0, g.data[15:0]};
      end

      // three stages cover flow-through and pipelined latency
      always_ff @(posedge clock or negedge rstN) begin
         if (!rstN) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
         end else begin
            s1_r <= it;
            s2_r <= s1_r;
            s3_r <= s2_r;
         end
      end
      assign pipeEmpty[b] = !s1_r.valid && !s2_r.valid && !s3_r.valid;
      assign pipeSel = ctrl_r[`TBM_CTRL_PIPE + b];
      assign wrIt = pipeSel ? s2_r : s1_r;
      assign rdIt = pipeSel ? s3_r : s2_r;

      // pin drive; bank C hands its pins to the sdram sequencer
      always_ff @(posedge clock or negedge rstN) begin
         if (!rstN) begin
            memOut[b] <= '{ceN: 4'hf, weN: 1'b1, doeN: 1'b1, default: '0};
         end else begin
            memOut[b].ceN <= (issue && ok) ? ~(4'h1 << chip) : 4'hf;
            memOut[b].weN <= !(issue && ok && g.write);
            memOut[b].addr <= wa;
            memOut[b].dout <= wrIt.data;
            memOut[b].doeN <= !(wrIt.valid && wrIt.write);
            memOut[b].parOut <= wrIt.chk ? genPar(wrIt.data, wrIt.apar,
               pmFirst_r) : {2{wrIt.under}};
            if (b == 2 && sdPinUse) begin
               memOut[b].addr <= sdPinAddr;
               memOut[b].dout <= sdPinDout;
               memOut[b].doeN <= sdPinDoeN;
               memOut[b].parOut <= sdPinPar;
            end
         end
      end

      // read return and parity check
      assign r = (b == 2 && sdRet.valid) ? sdRet : rdIt;
      assign rdD = (b == 2) ? memIn[b].din : {16'h0, memIn[b].din[15:0]};
      assign expPar = genPar(rdD, r.apar, pmFirst_r);
      assign mism = (b == 2) ? expPar != memIn[b].parIn
         : expPar[0] != memIn[b].parIn[0];
      assign perr[b] = r.valid && !r.write && r.chk && r.ok
         && mism;
      always_ff @(posedge clock or negedge rstN) begin
         if (!rstN) begin
            bankRsp[b] <= '0;
         end else begin
            bankRsp[b].valid <= r.valid && !r.write;
            bankRsp[b].agent <= r.agent;
            bankRsp[b].data <= rdD;
            bankRsp[b].underrun <= !r.chk && memIn[b].parIn[0];
         end
      end
   end

   // grant pulse to the agent picked on each bank
   always_comb begin
      gntNxt = '0;
      for (int b = 0; b < 3; b++) begin
         if (gHit[b]) gntNxt[gIdx[b]] = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) agentGnt <= '0;
      else agentGnt <= gntNxt;
   end

   // sdram row: 13 bits for 32M, 12 for 16M, x16 pairs give 32 bits
   assign sdGrant = gHit[2] && gReq[2].sdram;
   assign sdRow = ctrl_r[`TBM_CTRL_SD32] ? gReq[2].addr[24:12]
      : {1'b0, gReq[2].addr[23:12]};

   // sdram sequencer: manual, refresh, then access with auto-precharge
   always_comb begin
      stN = sdSt_r;
      cntN = (sdCnt_r != 4'h0) ? sdCnt_r - 4'h1 : 4'h0;
      cmdN = `TBM_SD_NOP;
      baN = 2'h0;
      sdPinUse = 1'b0;
      sdPinAddr = 20'h0;
      sdPinDout = 32'h0;
      sdPinDoeN = 1'b1;
      sdPinPar = 2'h0;
      sdRet = '0;
      refDone = 1'b0;
      manTake = 1'b0;
      case (sdSt_r)
         ST_IDLE: begin
            if (manGo_r) begin
               manTake = 1'b1;
               cmdN = man_r[`TBM_MAN_CMD +: 4];
               baN = man_r[`TBM_MAN_BA +: 2];
               sdPinUse = 1'b1;
               sdPinAddr = {7'h0, man_r[`TBM_MAN_ADDR +: 13]};
               stN = ST_REC;
               cntN = 4'(`TBM_RP_CYC - 1);
            end else if (backlog_r != 8'h0 && pipeEmpty[2]) begin
               cmdN = `TBM_SD_REF;
               refDone = 1'b1;
               stN = ST_REC;
               cntN = 4'(`TBM_RFC_CYC - 1);
            end else if (sdGrant) begin
               cmdN = `TBM_SD_ACT;
               baN = gReq[2].addr[11:10];
               sdPinUse = 1'b1;
               sdPinAddr = {7'h0, sdRow};
               stN = ST_RCD;
               cntN = 4'(`TBM_RCD_CYC - 1);
            end
         end
         ST_RCD: begin
            if (sdCnt_r == 4'h0) begin
               cmdN = sdItem_r.write ? `TBM_SD_WR : `TBM_SD_RD;
               baN = sdCol_r[12:11];
               sdPinUse = 1'b1;
               sdPinAddr = {9'h0, 1'b1, 2'h0, sdCol_r[7:0]};
               if (sdItem_r.write) begin
                  sdPinDout = sdItem_r.data;
                  sdPinDoeN = 1'b0;
                  sdPinPar = sdItem_r.chk ? genPar(sdItem_r.data,
                     sdItem_r.apar, pmFirst_r) : {2{sdItem_r.under}};
                  stN = ST_REC;
                  cntN = 4'(`TBM_WR_CYC + `TBM_RP_CYC - 1);
               end else begin
                  stN = ST_LAT;
                  cntN = 4'(`TBM_CAS_LAT);
               end
            end
         end
         ST_LAT: begin
            if (sdCnt_r == 4'h0) begin
               sdRet = sdItem_r;
               stN = ST_REC;
               cntN = 4'(`TBM_RP_CYC - 1);
            end
         end
         default: begin
            if (sdCnt_r == 4'h0) stN = ST_IDLE;
         end
      endcase
   end

   // sequencer state and sdram command pins
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         sdSt_r <= ST_IDLE;
         sdCnt_r <= 4'h0;
         sdItem_r <= '0;
         sdCol_r <= 13'h0;
         sdOut <= '{csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
            default: '0};
      end else begin
         sdSt_r <= stN;
         sdCnt_r <= cntN;
         if (sdIdle && sdGrant && !manGo_r) begin
            sdItem_r <= gItem[2];
            sdItem_r.ok <= 1'b1;
            sdCol_r <= {gReq[2].addr[11:10], 3'h0, gReq[2].addr[9:2]};
         end
         {sdOut.csN, sdOut.rasN, sdOut.casN, sdOut.weN} <= cmdN;
         sdOut.ba <= baN;
         sdOut.cke <= man_r[`TBM_MAN_CKE];
      end
   end
endmodule : tbm_ctrl
`default_nettype wire

// ==== include/tbm_params.svh ====
// constants of the three-bank memory controller
`ifndef TBM_PARAMS_SVH
`define TBM_PARAMS_SVH
// register word indices, byte address is four times the index
`define TBM_IX_PMASK_FIRST 12'h230
`define TBM_IX_PMASK_LAST 12'h234
`define TBM_IX_REF_PERIOD 12'h398
`define TBM_IX_REF_LIMIT 12'h39a
`define TBM_IX_CTRL 12'h240
`define TBM_IX_STAT 12'h244
`define TBM_IX_MAN 12'h248
// reset values
`define TBM_RST_PMASK 16'hffff
`define TBM_RST_REF_PERIOD 16'h0000
`define TBM_RST_REF_LIMIT 16'h0008
`define TBM_RST_CTRL 16'h0000
`define TBM_RST_MAN 20'h00007
// control fields
`define TBM_CTRL_PIPE 0
`define TBM_CTRL_RXPAR 3
`define TBM_CTRL_SD32 4
`define TBM_CTRL_SZ 5
`define TBM_CTRL_PRIO 11
// status fields
`define TBM_ST_PAR 0
`define TBM_ST_RANGE 3
`define TBM_ST_REFERR 6
`define TBM_ST_MANBUSY 7
`define TBM_ST_BACKLOG 8
// manual command fields
`define TBM_MAN_CMD 0
`define TBM_MAN_BA 4
`define TBM_MAN_ADDR 6
`define TBM_MAN_CKE 19
`define TBM_MAN_GO 31
// sram decode: smallest chip 2**17 bytes, bank limit 2**21 bytes
`define TBM_CHIP_LOG2_MIN 17
`define TBM_BANK_LOG2_MAX 21
// sdram timing
`define TBM_CLK_MHZ 25
`define TBM_T_RCD_NS 20
`define TBM_T_RP_NS 20
`define TBM_T_RFC_NS 70
`define TBM_T_WR_NS 15
`define TBM_CAS_LAT 2
`define TBM_NS2CYC(ns) (((ns) * `TBM_CLK_MHZ + 999) / 1000)
`define TBM_RCD_CYC `TBM_NS2CYC(`TBM_T_RCD_NS)
`define TBM_RP_CYC `TBM_NS2CYC(`TBM_T_RP_NS)
`define TBM_RFC_CYC `TBM_NS2CYC(`TBM_T_RFC_NS)
`define TBM_WR_CYC `TBM_NS2CYC(`TBM_T_WR_NS)
// sdram commands as {cs_n, ras_n, cas_n, we_n}
`define TBM_SD_NOP 4'h7
`define TBM_SD_ACT 4'h3
`define TBM_SD_RD 4'h5
`define TBM_SD_WR 4'h4
`define TBM_SD_REF 4'h1
// widths
`define TBM_AW 25
`define TBM_WAW 20
`define TBM_DW 32
`endif

// ==== include/tbm_pkg.sv ====
// types shared by the three-bank memory controller
`include "tbm_params.svh"
`default_nettype none
package tbm_pkg;
   typedef enum logic [1:0] {
      TBM_BANK_TX = 2'h0,
      TBM_BANK_RX = 2'h1,
      TBM_BANK_NET = 2'h2
   } tbm_bank_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RCD = 2'h1,
      ST_LAT = 2'h3,
      ST_REC = 2'h2
   } tbm_sd_e;
   typedef struct packed {
      logic valid;
      logic write;
      logic sdram;
      logic rxCirc;
      logic underrun;
      tbm_bank_e bank;
      logic [`TBM_AW-1:0] addr;
      logic [`TBM_DW-1:0] data;
   } tbm_req_s;
   typedef struct packed {
      logic valid;
      logic write;
      logic chk;
      logic under;
      logic ok;
      logic [1:0] agent;
      logic apar;
      logic [`TBM_DW-1:0] data;
   } tbm_pipe_s;
   typedef struct packed {
      logic valid;
      logic [1:0] agent;
      logic [`TBM_DW-1:0] data;
      logic underrun;
   } tbm_rsp_s;
   typedef struct packed {
      logic [3:0] ceN;
      logic weN;
      logic [`TBM_WAW-1:0] addr;
      logic [`TBM_DW-1:0] dout;
      logic doeN;
      logic [1:0] parOut;
   } tbm_sram_s;
   typedef struct packed {
      logic [`TBM_DW-1:0] din;
      logic [1:0] parIn;
   } tbm_memin_s;
   typedef struct packed {
      logic cke;
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic [1:0] ba;
   } tbm_sdram_s;
endpackage : tbm_pkg
`default_nettype wire

// ==== testbench/tbm_sram_model.sv ====
// behavioural synchronous sram, data one cycle after address
`default_nettype none
module tbm_sram_model
   import tbm_pkg::*;
(
   input wire logic clock,
   input wire tbm_sram_s pins,
   input wire logic badPar,
   output var tbm_memin_s back
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [33:0] mem [256];
   logic [7:0] wrAdr = 8'h0;
   logic wrPend = 1'b0;
   initial back = '0;
   // idle pins toggle, reads answer next cycle, write data lands a cycle late
   always @(posedge clock) begin
      if (wrPend && !pins.doeN)
         mem[wrAdr] <= {pins.dout, pins.parOut};
      wrPend <= pins.ceN != 4'hf && !pins.weN;
      wrAdr <= pins.addr[7:0];
      if (pins.ceN != 4'hf && pins.weN)
         back <= mem[pins.addr[7:0]] ^ {33'h0, badPar}; // bad parity on demand
      else
         back <= ~back;
   end
endmodule : tbm_sram_model
`default_nettype wire

// ==== testbench/tbm_ctrl_chk.sv ====
// port assertions for the three-bank memory controller
`default_nettype none
module tbm_ctrl_chk
   import tbm_pkg::*;
#(
   parameter int NAG = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbAck,
   input wire tbm_req_s agentReq [NAG],
   input wire logic [NAG-1:0] agentGnt,
   input wire tbm_rsp_s bankRsp [3],
   input wire tbm_sram_s memOut [3]
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // agent 0 granted onto bank A for a plain read or a write
   sequence rdA_s;
      agentGnt[0] && $past(agentReq[0].bank == TBM_BANK_TX
         && !agentReq[0].write && !agentReq[0].sdram);
   endsequence
   sequence wrA_s;
      agentGnt[0] && $past(agentReq[0].bank == TBM_BANK_TX
         && agentReq[0].write && !agentReq[0].sdram);
   endsequence
   ack_resp_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("bus request not answered next cycle");
   ack_cause_a: assert property (wbAck |-> $past(wbCyc && wbStb))
      else $error("ack without request");
   ack_pulse_a: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   gnt_cause_a: assert property (agentGnt[0] |-> $past(agentReq[0].valid))
      else $error("grant without request");
   gnt_space_a: assert property (agentGnt[0] |=> !agentGnt[0])
      else $error("grant on two cycles in a row");
   one_grant_a: assert property (agentGnt[0] && $past(agentReq[1].valid
      && agentReq[1].bank == agentReq[0].bank) |-> !agentGnt[1])
      else $error("two grants on one bank");
   rd_pins_a: assert property (rdA_s |-> memOut[0].weN
      && memOut[0].addr == $past(agentReq[0].addr[20:1]))
      else $error("bank a read pins wrong");
   wr_drive_a: assert property (wrA_s |-> ##[1:2] !memOut[0].doeN)
      else $error("bank a write data not driven");
   rd_return_a: assert property (rdA_s |-> ##[2:3]
      (bankRsp[0].valid && bankRsp[0].agent == 2'h0))
      else $error("bank a read not returned");
endmodule : tbm_ctrl_chk
bind tbm_ctrl tbm_ctrl_chk #(.NAG(NAG)) chk_u (.clock(clock), .rst_n(rst_n),
   .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .agentReq(agentReq),
   .agentGnt(agentGnt), .bankRsp(bankRsp), .memOut(memOut));
`default_nettype wire

// ==== testbench/three_bank_memory_controller_tb.sv ====
// register and agent tests for the three-bank memory controller
`include "tbm_params.svh"
`default_nettype none
module three_bank_memory_controller_tb
   import tbm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [13:0] wbAdr = 14'h0;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatIn = 32'h0;
   logic [31:0] wbDatOut;
   logic wbAck;
   tbm_req_s agentReq [4] = '{default: '0};
   logic [3:0] agentGnt;
   tbm_rsp_s bankRsp [3];
   tbm_sram_s memOut [3];
   tbm_memin_s memIn [3];
   tbm_sdram_s sdOut;
   logic [2:0] badPar = 3'h0;
   logic [31:0] q;
   tbm_rsp_s r;
   int n_errors = 0;
   int num_checks = 0;
   logic [11:0] ixs [6] = '{`TBM_IX_PMASK_FIRST, `TBM_IX_PMASK_LAST,
      `TBM_IX_REF_PERIOD, `TBM_IX_REF_LIMIT, `TBM_IX_CTRL, 12'h100};
   logic [31:0] rsv [6] = '{32'hffff, 32'hffff, 32'h0, 32'h8, 32'h0, 32'h0};
   always #20 clock = ~clock;
   // one memory model per bank
   for (genvar b = 0; b < 3; b++) begin : mem_g
      tbm_sram_model mem_u (.clock(clock), .pins(memOut[b]),
         .badPar(badPar[b]), .back(memIn[b]));
   end
   tbm_ctrl #(.NAG(4)) dut_u (.clock(clock), .rst_n(rst_n), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
      .agentReq(agentReq), .agentGnt(agentGnt), .bankRsp(bankRsp),
      .memOut(memOut), .memIn(memIn), .sdOut(sdOut));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string nm);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic close_out();
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // classic single wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [11:0] ix,
         input logic [31:0] d);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= {ix, 2'b00};
      wbDatIn <= d;
      wbSel <= 4'hf;
      do @(posedge clock); while (wbAck !== 1'b1);
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clock);
   endtask : wb
   // one agent access, held until granted; reads wait for the return
   task automatic acc(input int a, input logic w, input tbm_bank_e b,
         input logic [24:0] ad, input logic [31:0] d, input logic rc);
      agentReq[a] <= '{1'b1, w, 1'b0, rc, rc, b, ad, d};
      do @(posedge clock); while (agentGnt[a] !== 1'b1);
      agentReq[a].valid <= 1'b0;
      r = '0;
      while (!w && r.valid !== 1'b1) begin
         @(posedge clock);
         r = bankRsp[b];
      end
      repeat (2) @(posedge clock);
   endtask : acc
   // agents 0 and 1 read bank A together; each dropped once granted
   task automatic duo(input logic [3:0] first);
      agentReq[0] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, TBM_BANK_TX, 25'h10, 32'h0};
      agentReq[1] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, TBM_BANK_TX, 25'h10, 32'h0};
      for (int k = 0; k < 2; k++) begin
         do @(posedge clock); while (agentGnt[1:0] === 2'b00);
         if (k == 0)
            chk({28'h0, agentGnt}, {28'h0, first}, "first grant");
         if (agentGnt[0])
            agentReq[0].valid <= 1'b0;
         if (agentGnt[1])
            agentReq[1].valid <= 1'b0;
      end
      repeat (8) @(posedge clock);
   endtask : duo
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      foreach (ixs[i]) begin
         wb(1'b0, ixs[i], 32'h0);
         chk(q, rsv[i], "reset value");
      end
      wb(1'b1, `TBM_IX_PMASK_FIRST, 32'h5a5a00ff);
      wb(1'b1, `TBM_IX_PMASK_LAST, 32'h0);
      wb(1'b0, `TBM_IX_PMASK_FIRST, 32'h0);
      chk(q, 32'h00ff, "data mask");
      acc(0, 1'b1, TBM_BANK_TX, 25'h10, 32'h0103, 1'b0);
      chk({31'h0, mem_g[0].mem_u.mem[8][0]}, 32'h0, "parity pin");
      acc(1, 1'b0, TBM_BANK_TX, 25'h10, 32'h0, 1'b0);
      chk(r.data & 32'hffff, 32'h0103, "bank a data");
      chk({30'h0, r.agent}, 32'h1, "agent");
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h7, 32'h0, "parity clean");
      badPar <= 3'h1;
      acc(0, 1'b0, TBM_BANK_TX, 25'h10, 32'h0, 1'b0);
      badPar <= 3'h0;
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h1, 32'h1, "parity error");
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h1, 32'h1, "error kept");
      wb(1'b1, `TBM_IX_STAT, 32'h1);
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h1, 32'h0, "error cleared");
      acc(0, 1'b1, TBM_BANK_TX, 25'h80000, 32'h0, 1'b0);
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h8, 32'h8, "range error");
      acc(2, 1'b1, TBM_BANK_RX, 25'h20, 32'h0055, 1'b1);
      acc(2, 1'b0, TBM_BANK_RX, 25'h20, 32'h0, 1'b1);
      chk({31'h0, r.underrun}, 32'h1, "underrun");
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h2, 32'h0, "ring unchecked");
      wb(1'b1, `TBM_IX_CTRL, 32'h8);
      acc(2, 1'b0, TBM_BANK_RX, 25'h20, 32'h0, 1'b1);
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h2, 32'h2, "ring checked");
      acc(3, 1'b1, TBM_BANK_NET, 25'h40, 32'hdead0001, 1'b0);
      chk(mem_g[2].mem_u.mem[16][33:2], 32'hdead0001, "bank c pins");
      acc(3, 1'b0, TBM_BANK_NET, 25'h40, 32'h0, 1'b0);
      chk(r.data, 32'hdead0001, "bank c data");
      wb(1'b1, `TBM_IX_CTRL, 32'h0);
      duo(4'h1);
      wb(1'b1, `TBM_IX_CTRL, 32'h800);
      duo(4'h2);
      wb(1'b1, `TBM_IX_MAN, 32'h80080001);
      while ({sdOut.csN, sdOut.rasN, sdOut.casN, sdOut.weN} !== `TBM_SD_REF)
         @(posedge clock);
      chk({28'h0, sdOut.csN, sdOut.rasN, sdOut.casN, sdOut.weN},
         {28'h0, `TBM_SD_REF}, "manual command");
      chk({31'h0, sdOut.cke}, 32'h1, "manual cke");
      wb(1'b1, `TBM_IX_REF_LIMIT, 32'h0);
      wb(1'b1, `TBM_IX_REF_PERIOD, 32'h4);
      repeat (8) @(posedge clock);
      wb(1'b0, `TBM_IX_STAT, 32'h0);
      chk(q & 32'h40, 32'h40, "refresh backlog");
      close_out();
   end
endmodule : three_bank_memory_controller_tb
`default_nettype wire
